/* crc_consts.svh */
// Constants for the serial CRC generator and checker.
// Assumes inclusion by the CRC design file and the testbench only.
`ifndef CRC_CONSTS_SVH
`define CRC_CONSTS_SVH

`define CRC_WIDTH 16
// Feedback tap masks; bit i set means an XOR feeds register bit i.
`define CRC_TAPS_16 16'h8005
`define CRC_TAPS_16R 16'h4003
`define CRC_TAPS_16X 16'hA097
`define CRC_TAPS_12 16'h80F0
`define CRC_TAPS_8A 16'hB300
`define CRC_TAPS_8B 16'h0100
`define CRC_TAPS_CCITT 16'h1021
`define CRC_TAPS_CCITTR 16'h0811
// Preset images, right-justified polynomials keep their low bits clear.
`define CRC_PRESET_16 16'hFFFF
`define CRC_PRESET_12 16'hFFF0
`define CRC_PRESET_8 16'hFF00
`define CRC_ZERO 16'h0000
// Synchroniser depth for pin inputs.
`define CRC_SYNC_STAGES 2

`endif

/* crc_pkg.sv */
// Types for the serial CRC generator and checker.
// Assumes crc_consts.svh is available on the include path.
`default_nettype none
package crc_pkg;
    typedef enum logic [2:0] {
        CRC_SEL_16,
        CRC_SEL_16R,
        CRC_SEL_16X,
        CRC_SEL_12,
        CRC_SEL_8A,
        CRC_SEL_8B,
        CRC_SEL_CCITT,
        CRC_SEL_CCITTR
    } crc_sel_t;
endpackage
`default_nettype wire

/* crc_sync.sv */
// Two-stage synchroniser bank for the pin inputs of the CRC block.
// Assumes a single clock; the first stage is read by the second only.
`timescale 1ns/10ps
`default_nettype none
module crc_sync #(
    parameter int WIDTH = 8
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic reset,
    // Data
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
    logic [WIDTH-1:0] next_stage1;
    logic [WIDTH-1:0] next_stage2;

    always_comb begin
        next_stage1 = async_in;
        next_stage2 = stage1;
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            stage1 <= '0;
            stage2 <= '0;
        end else begin
            stage1 <= next_stage1;
            stage2 <= next_stage2;
        end
    end

    assign sync_out = stage2;
endmodule
`default_nettype wire

/* crc_gen_check.sv */
// Serial CRC generator and checker with eight selectable polynomials.
// Assumes all control pins come from outside mclk's domain.
//
// Behaviour
// R1: Sixteen-bit register advances one bit on each falling shift clock edge.
// R2: Three-bit select picks one of eight polynomials setting feedback taps.
// R3: Sixteen-bit codes map to CRC-16, reverse, long, CCITT and reverse.
// R4: Codes 3, 4, 5 select the degree-12 and two degree-8 polynomials.
// R5: Short polynomials are right-justified so check bits exit at the top.
// R6: Input bit XOR register top drives taps; top bit is the output.
// R7: Low check-word enable inhibits feedback so contents shift out.
// R8: Transmitter holds enable high over data, then low for check bits.
// R9: Receiver clocks data and check bits in with enable held high.
// R10: Error flag low when register all zero after final bit, else high.
// R11: Error flag holds until next shift edge, preset or clear.
// R12: High master clear forces the whole register to zero.
// R13: Low preset sets all, top twelve or top eight bits per degree.
// R14: Partner clears or presets before each new computation.
// R15: Clear wins over preset when both are asserted.
`timescale 1ns/10ps
`default_nettype none
`include "crc_consts.svh"
module crc_gen_check
    import crc_pkg::*;
(
    // Clock and reset
    input wire logic mclk,
    input wire logic reset,
    // Serial link from the data logic
    input wire logic shift_clock_n,
    input wire logic serial_in,
    input wire logic check_word_enable,
    // Control
    input wire logic [2:0] poly_select,
    input wire logic preset_n,
    input wire logic master_clear,
    // Results
    output logic serial_out,
    output logic error_flag
);
    // ------------------------------------------------------------
    // Check clocking
    // ------------------------------------------------------------
    // All checks below live in the mclk domain and sleep during reset.
    default clocking chk_cb @(posedge mclk);
    endclocking
    default disable iff (reset);

    // ------------------------------------------------------------
    // Input synchronisation
    // ------------------------------------------------------------
    // The shift clock and the preset idle high, but the synchroniser
    // clears to zero. Both are inverted on the way in so that its reset
    // state reads as idle; otherwise the first cycles after reset would
    // show a false falling edge and a false preset.
    localparam int NSYNC = 8;
    logic [NSYNC-1:0] pins_raw;
    logic [NSYNC-1:0] pins;
    logic clk_s;
    logic clk_low_s;
    logic din_s;
    logic cwe_s;
    logic [2:0] sel_s;
    logic preset_n_s;
    logic preset_s;
    logic clear_s;

    assign pins_raw = {~shift_clock_n, serial_in, check_word_enable,
                       poly_select, ~preset_n, master_clear};

    crc_sync #(
        .WIDTH(NSYNC)
    ) u_sync (
        .mclk(mclk),
        .reset(reset),
        .async_in(pins_raw),
        .sync_out(pins)
    );

    assign {clk_low_s, din_s, cwe_s, sel_s, preset_s, clear_s} = pins;
    assign clk_s = ~clk_low_s;
    assign preset_n_s = ~preset_s;

    // ------------------------------------------------------------
    // Polynomial decode
    // ------------------------------------------------------------
    // A tap mask holds the coefficients below the top term, bit i for
    // x^i. Short polynomials sit in the upper bits, so their low bits
    // never receive feedback and the check bits still leave at bit 15.
    function automatic logic [15:0] tap_mask(input logic [2:0] sel);
        case (crc_sel_t'(sel)) // R2
            CRC_SEL_16: tap_mask = `CRC_TAPS_16; // R3
            CRC_SEL_16R: tap_mask = `CRC_TAPS_16R;
            CRC_SEL_16X: tap_mask = `CRC_TAPS_16X;
            CRC_SEL_12: tap_mask = `CRC_TAPS_12; // R4 R5
            CRC_SEL_8A: tap_mask = `CRC_TAPS_8A;
            CRC_SEL_8B: tap_mask = `CRC_TAPS_8B;
            CRC_SEL_CCITT: tap_mask = `CRC_TAPS_CCITT;
            CRC_SEL_CCITTR: tap_mask = `CRC_TAPS_CCITTR;
            default: tap_mask = `CRC_TAPS_16;
        endcase
    endfunction

    function automatic logic [15:0] preset_image(input logic [2:0] sel);
        case (crc_sel_t'(sel)) // R13
            CRC_SEL_12: preset_image = `CRC_PRESET_12;
            CRC_SEL_8A: preset_image = `CRC_PRESET_8;
            CRC_SEL_8B: preset_image = `CRC_PRESET_8;
            default: preset_image = `CRC_PRESET_16;
        endcase
    endfunction

    // ------------------------------------------------------------
    // Shift register and error flag
    // ------------------------------------------------------------
    // Preset and clear are levels, so they act on every cycle they are
    // held rather than waiting for a shift edge; the synchroniser adds
    // two cycles of latency, an accepted price for metastability safety.
    logic [15:0] crc;
    logic [15:0] next_crc;
    logic clk_prev;
    logic fall;
    logic fb;
    logic next_error;
    logic next_out;

    assign fall = clk_prev & ~clk_s; // R1

    always_comb begin
        fb = (din_s ^ crc[15]) & cwe_s; // R6 R7
        next_crc = crc;
        // Clear is tested first so it wins over preset, and both win over
        // a shift edge that arrives while they are held.
        if (clear_s) begin
            next_crc = `CRC_ZERO; // R12 R15
        end else if (!preset_n_s) begin
            next_crc = preset_image(sel_s); // R13
        end else if (fall) begin
            // With feedback off the register is a plain shifter. R7
            next_crc = {crc[14:0], 1'b0} ^ (tap_mask(sel_s) & {16{fb}});
        end
        next_out = next_crc[15]; // R6
        next_error = (next_crc != `CRC_ZERO); // R10 R11
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            crc <= `CRC_ZERO;
            // The edge detector starts at the idle high level.
            clk_prev <= 1'b1;
            serial_out <= 1'b0;
            error_flag <= 1'b0;
        end else begin
            crc <= next_crc;
            clk_prev <= clk_s;
            serial_out <= next_out;
            error_flag <= next_error;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    // The checks watch the synchronised pins, so they judge the register
    // as the logic sees it, two cycles behind the pins. They avoid the
    // raw pins on purpose: a check on those would have to model the
    // synchroniser latency and would only restate it.
    chk_clear_zeroes: assert property ( // R12
        clear_s |=> (crc == `CRC_ZERO) && !error_flag)
        else $error("clear did not zero the register");
    chk_clear_priority: assert property ( // R15
        clear_s && !preset_n_s |=> crc == `CRC_ZERO)
        else $error("preset overrode clear");
    chk_preset_image: assert property ( // R13
        !clear_s && !preset_n_s |=> crc == preset_image($past(sel_s)))
        else $error("preset image wrong for selected degree");
    chk_preset_byte: assert property ( // R13
        !clear_s && !preset_n_s && sel_s == 3'h5 |=> crc == `CRC_PRESET_8)
        else $error("eight-bit preset image wrong");
    chk_preset_error: assert property ( // R13
        !clear_s && !preset_n_s |=> error_flag && serial_out)
        else $error("preset did not raise the flag and the output");
    chk_hold_no_edge: assert property ( // R1
        !clear_s && preset_n_s && !fall |=> $stable(crc))
        else $error("register moved without a falling edge");
    chk_flag_holds: assert property ( // R11
        !clear_s && preset_n_s && !fall |=> $stable(error_flag))
        else $error("error flag changed between shift edges");
    chk_output_holds: assert property ( // R11
        !clear_s && preset_n_s && !fall |=> $stable(serial_out))
        else $error("serial output changed between shift edges");
    chk_shift_plain: assert property ( // R7
        !clear_s && preset_n_s && fall && !cwe_s
        |=> crc == {$past(crc[14:0]), 1'b0})
        else $error("feedback not inhibited");
    chk_feedback_step: assert property ( // R6
        !clear_s && preset_n_s && fall && cwe_s
        |=> crc == ({$past(crc[14:0]), 1'b0}
                    ^ (tap_mask($past(sel_s))
                       & {16{$past(din_s) ^ $past(crc[15])}})))
        else $error("feedback step wrong");
    chk_output_msb: assert property ( // R6
        serial_out == crc[15])
        else $error("serial output not register top");
    chk_error_state: assert property ( // R10
        error_flag == (crc != `CRC_ZERO))
        else $error("error flag disagrees with register");
    chk_short_low: assert property ( // R5
        !clear_s && !preset_n_s && sel_s == 3'h4 |=> crc[7:0] == 8'h00)
        else $error("short preset not right-justified");
    chk_short_low12: assert property ( // R5
        !clear_s && !preset_n_s && sel_s == 3'h3 |=> crc[3:0] == 4'h0)
        else $error("twelve-bit preset not right-justified");
    chk_nibble_kept: assert property ( // R5
        sel_s == 3'h3 && crc[3:0] == 4'h0 && !clear_s
        |=> crc[3:0] == 4'h0)
        else $error("twelve-bit shift disturbed the low bits");

    cov_shift_fb: cover property (fall && cwe_s && fb);
    cov_shift_out: cover property (fall && !cwe_s);
    cov_clean_check: cover property (fall ##1 !error_flag);
    cov_preset8: cover property (!preset_n_s && sel_s == 3'h5);
    cov_clear_wins: cover property (clear_s && !preset_n_s);
endmodule
`default_nettype wire

/* crc_partner.sv */
// Serial data logic model that clocks bits into the CRC block.
// Assumes shift_bit is entered just after a rising mclk edge.
`timescale 1ns/10ps
`default_nettype none
module crc_partner (
    // Clock
    input wire logic mclk,
    // Serial link
    output logic shift_clock_n,
    output logic serial_in,
    output logic check_word_enable
);
    initial begin
        shift_clock_n = 1'b1;
        serial_in = 1'b0;
        check_word_enable = 1'b1;
    end
    // Both clock phases last four cycles so the synchroniser sees each one.
    task automatic shift_bit(input logic d, input logic we);
        serial_in = d;
        check_word_enable = we;
        repeat (4) @(posedge mclk);
        #1 shift_clock_n = 1'b0;
        repeat (4) @(posedge mclk);
        #1 shift_clock_n = 1'b1;
    endtask
endmodule
`default_nettype wire

/* serial_crc_generator_checker_tb.sv */
// Self-checking bench for the serial CRC generator and checker.
// Assumes crc_consts.svh on the include path and the partner model.
`timescale 1ns/10ps
`default_nettype none
`include "crc_consts.svh"
module serial_crc_generator_checker_tb;
    typedef struct {int due; logic [1:0] val;} crc_note_t;
`define CHK(what, exp, got) begin \
    checks++; \
    if ((got) !== (exp)) begin \
        fail_count++; \
        $display("unexpected %s expected %b seen %b", what, exp, got); \
    end \
end
    logic mclk = 1'b0;
    logic reset = 1'b1;
    logic [2:0] poly_select = 3'h0;
    logic preset_n = 1'b1;
    logic master_clear = 1'b0;
    wire logic shift_clock_n;
    wire logic serial_in;
    wire logic check_word_enable;
    logic serial_out;
    logic error_flag;
    logic [15:0] model;
    logic [15:0] taps;
    logic [15:0] msg;
    logic [15:0] chk;
    int fail_count = 0;
    int checks = 0;
    int cyc = 0;
    int seed = 32'h3B624532;
    crc_note_t exp_q[$];
    crc_note_t note;

    crc_gen_check dut (.mclk(mclk), .reset(reset),
        .shift_clock_n(shift_clock_n), .serial_in(serial_in),
        .check_word_enable(check_word_enable), .poly_select(poly_select),
        .preset_n(preset_n), .master_clear(master_clear),
        .serial_out(serial_out), .error_flag(error_flag));
    crc_partner partner (.mclk(mclk), .shift_clock_n(shift_clock_n),
        .serial_in(serial_in), .check_word_enable(check_word_enable));

    function automatic logic [15:0] taps_of(input logic [2:0] s);
        case (s)
            3'h0: return `CRC_TAPS_16;
            3'h1: return `CRC_TAPS_16R;
            3'h2: return `CRC_TAPS_16X;
            3'h3: return `CRC_TAPS_12;
            3'h4: return `CRC_TAPS_8A;
            3'h5: return `CRC_TAPS_8B;
            3'h6: return `CRC_TAPS_CCITT;
            default: return `CRC_TAPS_CCITTR;
        endcase
    endfunction

    task automatic wrap_up();
        if (fail_count == 0 && checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic expect_now(input int lag);
        exp_q.push_back('{cyc + lag, {model[15], |model}});
    endtask

    task automatic shift(input logic d, input logic we);
        if (we && (d ^ model[15])) model = {model[14:0], 1'b0} ^ taps;
        else model = {model[14:0], 1'b0};
        expect_now(8);
        partner.shift_bit(d, we);
    endtask

    task automatic apply_init(input logic clr, input logic pre);
        master_clear = clr;
        preset_n = ~pre;
        if (clr) model = 16'h0000;
        else if (poly_select == 3'h3) model = `CRC_PRESET_12;
        else if (poly_select[2:1] == 2'h2) model = `CRC_PRESET_8;
        else model = `CRC_PRESET_16;
        expect_now(5);
        repeat (6) @(posedge mclk);
        #1 master_clear = 1'b0;
        preset_n = 1'b1;
        repeat (4) @(posedge mclk);
        #1;
    endtask

    // The watcher pops a note once its answer is due and compares it.
    always @(posedge mclk) begin
        cyc++;
        #2;
        if (exp_q.size() > 0 && exp_q[0].due <= cyc) begin
            note = exp_q.pop_front();
            `CHK("serial_out", note.val[1], serial_out)
            `CHK("error_flag", note.val[0], error_flag)
        end
    end

    initial forever #5 mclk = ~mclk;

    initial begin
        repeat (20000) @(posedge mclk);
        fail_count++;
        wrap_up();
    end

    initial begin
        repeat (16) @(posedge mclk);
        #1 reset = 1'b0;
        model = 16'h0000;
        expect_now(1);
        for (int s = 0; s < 8; s++) begin
            poly_select = s[2:0];
            taps = taps_of(s[2:0]);
            repeat (4) @(posedge mclk);
            #1;
            apply_init(1'b0, 1'b1);
            msg = 16'($random(seed));
            for (int i = 0; i < 12; i++) shift(msg[i], 1'b1);
            chk = model;
            for (int i = 0; i < 16; i++) shift(1'b0, 1'b0);
            apply_init(1'b0, 1'b1);
            // Odd codes get one corrupted bit, so the flag must rise.
            msg[s] = msg[s] ^ s[0];
            for (int i = 0; i < 12; i++) shift(msg[i], 1'b1);
            for (int i = 15; i >= 0; i--) shift(chk[i], 1'b1);
        end
        apply_init(1'b1, 1'b1);
        // Preset first, so that the lone clear has something to remove.
        apply_init(1'b0, 1'b1);
        apply_init(1'b1, 1'b0);
        wrap_up();
    end
endmodule
`default_nettype wire
